// ===== src/acr_pkg.sv
// Purpose: constants for the converter configuration register bank
// Assumes: 6-bit register select, registers of 8, 16 or 24 bits
// Notes: masks give the bits that a serial write may change
package acr_pkg;
  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [5:0] A_STAT = 6'h00;
  localparam logic [5:0] A_CTRL = 6'h01;
  localparam logic [5:0] A_RES = 6'h02;
  localparam logic [5:0] A_IO = 6'h03;
  localparam logic [5:0] A_VB = 6'h04;
  localparam logic [5:0] A_ID = 6'h05;
  localparam logic [5:0] A_FLT = 6'h06;
  localparam logic [5:0] A_FEN = 6'h07;
  localparam logic [5:0] A_MCK = 6'h08;
  localparam logic [5:0] A_CH0 = 6'h09;
  localparam logic [5:0] A_CHL = 6'h18;
  localparam logic [5:0] A_CF0 = 6'h19;
  localparam logic [5:0] A_CFL = 6'h20;
  localparam logic [5:0] A_FI0 = 6'h21;
  localparam logic [5:0] A_FIL = 6'h28;
  localparam logic [5:0] A_OF0 = 6'h29;
  localparam logic [5:0] A_OFL = 6'h30;
  localparam logic [5:0] A_GN0 = 6'h31;
  localparam logic [5:0] A_GNL = 6'h38;
  localparam logic [5:0] A_MSC = 6'h39;
  localparam logic [5:0] A_QC = 6'h3a;
  localparam logic [5:0] A_QS = 6'h3b;
  localparam logic [5:0] A_QT = 6'h3c;
  localparam logic [5:0] A_QD = 6'h3d;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [15:0] R_CTRL = 16'h4000;
  localparam logic [15:0] R_FEN = 16'h0040;
  localparam logic [23:0] R_CH0 = 24'h800100;
  localparam logic [23:0] R_CHN = 24'h000100;
  localparam logic [23:0] R_FI = 24'h002030;
  localparam logic [23:0] R_OF = 24'h800000;
  localparam logic [23:0] R_GN = 24'h555555;
  localparam logic [23:0] R_QC = 24'h040200;
  localparam logic [23:0] R_QT = 24'hfff000;
  // ************************************************************
  // writable bit masks, reserved bits read zero
  // ************************************************************
  localparam logic [15:0] M_CTRL = 16'h7f7f;
  localparam logic [15:0] M_IO = 16'h07ee;
  localparam logic [15:0] M_VB = 16'hcc33;
  localparam logic [15:0] M_FLT = 16'h0fff;
  localparam logic [15:0] M_FEN = 16'h1fff;
  localparam logic [23:0] M_FI = 24'hfff7ff;
  // ************************************************************
  // command byte and fault fields
  // ************************************************************
  localparam int C_GATE = 7;
  localparam int C_RD = 6;
  localparam int F_RDERR = 4;
  localparam int F_WRERR = 3;
  localparam int S_POR = 4;
  localparam logic [4:0] L8 = 5'd8;
  localparam logic [4:0] L16 = 5'd16;
  localparam logic [4:0] L24 = 5'd24;
  typedef enum logic [2:0] {
    ST_CMD = 3'b001,
    ST_WR = 3'b010,
    ST_RD = 3'b100
  } acr_st_t;
endpackage : acr_pkg

// ===== src/acr_spi_sync.sv
// Purpose: bring serial pins into the clk domain
// Assumes: idle clock high, chip select idle high
// Notes: a level moves once the second and third stage agree
`timescale 1ns/1ps
`default_nettype none
module acr_spi_sync
  import acr_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // sync reset
  input wire logic sclk, // serial clock pin
  input wire logic cs_n, // chip select pin
  input wire logic mosi, // serial data in pin
  output logic rise, // serial clock rising pulse
  output logic fall, // serial clock falling pulse
  output logic csn_lvl, // filtered chip select
  output logic din_lvl // filtered data level
);
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [2:0] lvl_r;
  logic [2:0] agree;

  assign agree = ~(s2_r ^ s3_r);

  // ************************************************************
  // three stage capture, s1 feeds only s2
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_r <= 3'h6;
      s2_r <= 3'h6;
      s3_r <= 3'h6;
    end
    else
    begin
      s1_r <= {sclk, cs_n, mosi};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lvl_r <= 3'h6;
      rise <= 1'b0;
      fall <= 1'b0;
    end
    else
    begin
      lvl_r <= (agree & s3_r) | (~agree & lvl_r);
      rise <= agree[2] & s3_r[2] & ~lvl_r[2];
      fall <= agree[2] & ~s3_r[2] & lvl_r[2];
    end
  end

  assign csn_lvl = lvl_r[1];
  assign din_lvl = lvl_r[0];
endmodule : acr_spi_sync
`default_nettype wire

// ===== src/acr_reg_bank.sv
// Purpose: serial register bank of a sigma-delta converter
// Assumes: mode 3 serial link, clk over ten times sclk so miso moves before the next rising sclk
// Notes: one register per command byte, msb first
// Summary of operation
// - a serial write changes only writable bits and leaves read-only bits as they were.
// - read-only registers hold only read-only bits, mixed ones add writable bits.
// - channel setups reset to 0x800100 for channel zero and 0x000100 for the rest.
// - gain coefficients reset to the factory value, nominally 0x555555.
// - eight offset coefficients at 0x29 to 0x30 reset to 0x800000.
// - eight filter words at 0x21 to 0x28 reset to 0x002030.
// - eight setup words at 0x19 to 0x20 reset to zero.
`timescale 1ns/1ps
`default_nettype none
module acr_reg_bank
  import acr_pkg::*;
#(
  parameter logic [23:0] GAIN_FACTORY = R_GN,
  parameter logic [7:0] ID_VALUE = 8'ha6 // value is arbitrary
)
(
  input wire logic clk, // 20 MHz clock
  input wire logic rst, // sync reset
  input wire logic sclk, // serial clock pin
  input wire logic cs_n, // chip select pin
  input wire logic mosi, // serial data in
  output logic miso, // serial data out
  output logic miso_oe, // data out enable
  input wire logic rdy_in, // conversion ready
  input wire logic [3:0] current_channel, // active channel
  input wire logic [23:0] result_in, // conversion result
  input wire logic [7:0] mclk_tally_in, // master clock tally
  input wire logic [7:0] q_stat_in, // queue status
  input wire logic [23:0] q_data_in, // queue head word
  input wire logic [11:0] fault_set, // core fault pulses
  output logic result_rd, // result read pulse
  output logic q_pop, // queue pop pulse
  output logic [15:0] ctrl_o, // converter control
  output logic [15:0] io_o, // pin io control
  output logic [15:0] vb_o, // bias control
  output logic [11:0] fault_o, // fault flags
  output logic [15:0] fen_o, // fault enable
  output logic [15:0] misc_o, // misc settings
  output logic [23:0] qc_o, // queue control
  output logic [23:0] qt_o, // queue threshold
  output logic [15:0][23:0] ch_o, // channel setups
  output logic [7:0][15:0] cf_o, // setup configs
  output logic [7:0][23:0] fi_o, // filter configs
  output logic [7:0][23:0] of_o, // offset coeffs
  output logic [7:0][23:0] gn_o // gain coeffs
);
  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic logic in_rng(input logic [5:0] a, input logic [5:0] lo,
                                  input logic [5:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng
  function automatic logic [4:0] reg_len(input logic [5:0] a);
    reg_len = L8;
    if (a == A_CTRL || a == A_IO || a == A_VB || a == A_FLT ||
        a == A_FEN || a == A_MSC || in_rng(a, A_CF0, A_CFL))
      reg_len = L16;
    if (a == A_RES || a == A_QC || a == A_QT || a == A_QD ||
        in_rng(a, A_CH0, A_CHL) || in_rng(a, A_FI0, A_GNL))
      reg_len = L24;
  endfunction : reg_len
  function automatic logic is_ro(input logic [5:0] a);
    is_ro = (a == A_STAT) || (a == A_RES) || (a == A_ID) ||
            (a == A_MCK) || (a == A_QS) || (a == A_QD);
  endfunction : is_ro
  function automatic logic [23:0] merge(input logic [23:0] old, input logic [23:0] nw,
                                        input logic [23:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge
  acr_st_t st_r;
  logic rise, fall, csn, din, cmd_done, last, commit, ro_hit, por_r, main_err;
  logic [4:0] cnt_r, len;
  logic [5:0] addr_r;
  logic [23:0] rx_r, tx_r, word, rdval, rdal;
  logic [7:0] cmd;
  logic [3:0] chi;
  logic [2:0] sti;
  acr_spi_sync u_sync (
    .clk(clk),
    .rst(rst),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .rise(rise),
    .fall(fall),
    .csn_lvl(csn),
    .din_lvl(din)
  );
  assign word = {rx_r[22:0], din};
  assign cmd = word[7:0];
  assign len = reg_len(addr_r);
  assign last = (cnt_r == len - 5'd1);
  assign cmd_done = rise && !csn && st_r == ST_CMD && cnt_r == 5'd7;
  assign commit = rise && !csn && st_r == ST_WR && last;
  assign ro_hit = is_ro(addr_r) || addr_r > A_QD;
  assign chi = 4'(addr_r - A_CH0);
  assign sti = 3'(addr_r - A_CF0);
  assign main_err = |(fault_o & fen_o[11:0]);
  // ************************************************************
  // framing
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (rst || csn)
    begin
      st_r <= ST_CMD;
      cnt_r <= 5'd0;
    end
    else if (rise)
    begin
      cnt_r <= cnt_r + 5'd1;
      unique case (st_r)
        ST_CMD:
        begin
          if (cnt_r == 5'd7)
          begin
            cnt_r <= 5'd0;
            // a set gate bit leaves the byte unused
            if (!cmd[C_GATE])
              st_r <= cmd[C_RD] ? ST_RD : ST_WR;
          end
        end
        ST_WR, ST_RD:
        begin
          if (last)
          begin
            st_r <= ST_CMD;
            cnt_r <= 5'd0;
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_r <= 24'h000000;
      addr_r <= 6'h00;
    end
    else if (rise && !csn)
    begin
      rx_r <= word;
      if (cmd_done && !cmd[C_GATE])
        addr_r <= cmd[5:0];
    end
  end
  // ************************************************************
  // read path
  // ************************************************************
  always_comb
  begin
    rdval = 24'h000000;
    case (cmd[5:0])
      A_STAT: rdval = {16'h0000, rdy_in, main_err, 1'b0, por_r, current_channel};
      A_CTRL: rdval = {8'h00, ctrl_o};
      A_RES: rdval = result_in;
      A_IO: rdval = {8'h00, io_o};
      A_VB: rdval = {8'h00, vb_o};
      A_ID: rdval = {16'h0000, ID_VALUE};
      A_FLT: rdval = {12'h000, fault_o};
      A_FEN: rdval = {8'h00, fen_o};
      A_MCK: rdval = {16'h0000, mclk_tally_in};
      A_MSC: rdval = {8'h00, misc_o};
      A_QC: rdval = qc_o;
      A_QS: rdval = {16'h0000, q_stat_in};
      A_QT: rdval = qt_o;
      A_QD: rdval = q_data_in;
      default:
      begin
        if (in_rng(cmd[5:0], A_CH0, A_CHL))
          rdval = ch_o[4'(cmd[5:0] - A_CH0)];
        else if (in_rng(cmd[5:0], A_CF0, A_CFL))
          rdval = {8'h00, cf_o[3'(cmd[5:0] - A_CF0)]};
        else if (in_rng(cmd[5:0], A_FI0, A_FIL))
          rdval = fi_o[3'(cmd[5:0] - A_FI0)];
        else if (in_rng(cmd[5:0], A_OF0, A_OFL))
          rdval = of_o[3'(cmd[5:0] - A_OF0)];
        else if (in_rng(cmd[5:0], A_GN0, A_GNL))
          rdval = gn_o[3'(cmd[5:0] - A_GN0)];
      end
    endcase
    // left align so the msb leaves first
    rdal = rdval;
    if (reg_len(cmd[5:0]) == L8)
      rdal = {rdval[7:0], 16'h0000};
    else if (reg_len(cmd[5:0]) == L16)
      rdal = {rdval[15:0], 8'h00};
  end
  always_ff @(posedge clk)
  begin
    if (rst || csn)
    begin
      tx_r <= 24'h000000;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end
    else
    begin
      miso_oe <= 1'b1;
      if (cmd_done && !cmd[C_GATE] && cmd[C_RD])
        tx_r <= rdal;
      else if (fall && st_r == ST_RD)
      begin
        miso <= tx_r[23];
        tx_r <= {tx_r[22:0], 1'b0};
      end
    end
  end
  // ************************************************************
  // read side effects
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      result_rd <= 1'b0;
      q_pop <= 1'b0;
      por_r <= 1'b1;
    end
    else
    begin
      result_rd <= cmd_done && cmd[7:6] == 2'b01 && cmd[5:0] == A_RES;
      q_pop <= cmd_done && cmd[7:6] == 2'b01 && cmd[5:0] == A_QD;
      // power-on flag drops once status has been read
      if (cmd_done && cmd[7:6] == 2'b01 && cmd[5:0] == A_STAT)
        por_r <= 1'b0;
    end
  end
  // ************************************************************
  // single registers
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_o <= R_CTRL;
      io_o <= 16'h0000;
      vb_o <= 16'h0000;
      fen_o <= R_FEN;
      misc_o <= 16'h0000;
      qc_o <= R_QC;
      qt_o <= R_QT;
    end
    else if (commit)
    begin
      // masks keep reserved and read-only bits untouched
      case (addr_r)
        A_CTRL: ctrl_o <= 16'(merge({8'h00, ctrl_o}, word, {8'h00, M_CTRL}));
        A_IO: io_o <= 16'(merge({8'h00, io_o}, word, {8'h00, M_IO}));
        A_VB: vb_o <= 16'(merge({8'h00, vb_o}, word, {8'h00, M_VB}));
        A_FEN: fen_o <= 16'(merge({8'h00, fen_o}, word, {8'h00, M_FEN}));
        A_MSC: misc_o <= word[15:0];
        A_QC: qc_o <= word;
        A_QT: qt_o <= word;
        default: ;
      endcase
    end
  end
  // faults are sticky; a new event beats a same-cycle clear
  always_ff @(posedge clk)
  begin
    if (rst)
      fault_o <= 12'h000;
    else
    begin
      for (int i = 0; i < 12; i++)
      begin
        if (fault_set[i])
          fault_o[i] <= 1'b1;
        else if (commit && addr_r == A_FLT && word[i] && M_FLT[i])
          fault_o[i] <= 1'b0;
      end
      if (commit && ro_hit)
        fault_o[F_WRERR] <= 1'b1;
      if (cmd_done && !cmd[C_GATE] && cmd[C_RD] && cmd[5:0] > A_QD)
        fault_o[F_RDERR] <= 1'b1;
    end
  end
  // ************************************************************
  // per channel and per setup arrays
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ch_o[0] <= R_CH0;
      for (int i = 1; i < 16; i++)
        ch_o[i] <= R_CHN;
    end
    else if (commit && in_rng(addr_r, A_CH0, A_CHL))
      ch_o[chi] <= word;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 8; i++)
      begin
        cf_o[i] <= 16'h0000;
        fi_o[i] <= R_FI;
        of_o[i] <= R_OF;
        gn_o[i] <= GAIN_FACTORY;
      end
    end
    else if (commit)
    begin
      if (in_rng(addr_r, A_CF0, A_CFL))
        cf_o[sti] <= word[15:0];
      if (in_rng(addr_r, A_FI0, A_FIL))
        fi_o[sti] <= merge(fi_o[sti], word, M_FI);
      if (in_rng(addr_r, A_OF0, A_OFL))
        of_o[sti] <= word;
      if (in_rng(addr_r, A_GN0, A_GNL))
        gn_o[sti] <= word;
    end
  end
  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence gated_cmd_s;
    cmd_done && !cmd[C_GATE];
  endsequence
  sequence rd_cmd_s;
    gated_cmd_s and cmd_done && cmd[C_RD];
  endsequence
  reserved_zero_a: assert property (
    (ctrl_o & ~M_CTRL) == 16'h0000 && (io_o & ~M_IO) == 16'h0000 &&
    (fi_o[sti] & ~M_FI) == 24'h000000)
    else $error("reserved bits changed");
  ro_write_flag_a: assert property (
    commit && ro_hit && !rst |=> fault_o[F_WRERR] && $stable(ctrl_o))
    else $error("read-only write not flagged");
  chan_reset_a: assert property (
    $fell(rst) |-> ch_o[0] == R_CH0 && ch_o[15] == R_CHN)
    else $error("channel reset value wrong");
  gain_reset_a: assert property (
    $fell(rst) |-> gn_o[0] == GAIN_FACTORY && gn_o[7] == GAIN_FACTORY)
    else $error("gain reset value wrong");
  offset_reset_a: assert property (
    $fell(rst) |-> of_o[0] == R_OF && of_o[7] == R_OF)
    else $error("offset reset value wrong");
  filter_reset_a: assert property (
    $fell(rst) |-> fi_o[0] == R_FI && fi_o[7] == R_FI)
    else $error("filter reset value wrong");
  cfg_reset_a: assert property (
    $fell(rst) |-> cf_o[0] == 16'h0000 && cf_o[7] == 16'h0000)
    else $error("setup reset value wrong");
  read_entry_a: assert property (
    rd_cmd_s |=> st_r == ST_RD && addr_r == $past(cmd[5:0]))
    else $error("read command not taken");
  gate_block_a: assert property (
    cmd_done && cmd[C_GATE] |=> st_r == ST_CMD && $stable(addr_r))
    else $error("gated command acted on");
  offset_store_a: assert property (
    commit && in_rng(addr_r, A_OF0, A_OFL) |=> of_o[$past(sti)] == $past(word))
    else $error("offset write lost");
endmodule : acr_reg_bank
`default_nettype wire

// ===== verif/acr_host_model.sv
// Purpose: serial host that drives the register bank pins
// Assumes: mode 3 link, serial clock idles high
// Notes: every pin moves on the falling clk edge
`timescale 1ns/1ps
`default_nettype none
module acr_host_model (
  input wire logic clk, // system clock
  input wire logic miso, // device data out
  output logic sclk, // serial clock
  output logic cs_n, // chip select
  output logic mosi // serial data out
);
  // ******************************
  // serial transfers
  // ******************************
  // miso moves up to 6 clk after a fall, so sample 8 clk later
  localparam int HALF = 8;
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic shift(input logic [23:0] wd, input int nb, output logic [23:0] rd);
    rd = 24'h0;
    for (int i = nb - 1; i >= 0; i--)
    begin
      sclk = 1'b0;
      mosi = wd[i];
      tick(HALF);
      rd[i] = miso;
      sclk = 1'b1;
      tick(HALF);
    end
  endtask : shift
  task automatic access(input logic rd_en, input logic [5:0] a, input int nb,
                        input logic [23:0] wd, output logic [23:0] rd);
    logic [23:0] unused;
    shift({16'h0, 1'b0, rd_en, a}, 8, unused);
    shift(wd, nb, rd);
  endtask : access
  task automatic open_frame();
    cs_n = 1'b0;
    tick(6);
  endtask : open_frame
  task automatic close_frame();
    tick(HALF);
    cs_n = 1'b1;
    mosi = 1'b0; // pull-down level once released
    tick(8);
  endtask : close_frame
  task automatic xfer(input logic rd_en, input logic [5:0] a, input int nb,
                      input logic [23:0] wd, output logic [23:0] rd);
    open_frame();
    access(rd_en, a, nb, wd, rd);
    close_frame();
  endtask : xfer
endmodule : acr_host_model
`default_nettype wire

// ===== verif/adc_user_config_register_map_test.sv
// Purpose: self-checking bench for the register bank
// Assumes: all serial traffic goes through the host model
// Notes: the reset scan dominates the run length
`timescale 1ns/1ps
`default_nettype none
module adc_user_config_register_map_test;
  logic clk, rst, sclk, cs_n, mosi, miso, miso_oe, rdy_in, result_rd, q_pop;
  logic [3:0] current_channel;
  logic [7:0] mclk_tally_in, q_stat_in;
  logic [11:0] fault_set, fault_o;
  logic [15:0] ctrl_o, io_o, vb_o, fen_o, misc_o;
  logic [23:0] result_in, q_data_in, qc_o, qt_o;
  logic [15:0][23:0] ch_o;
  logic [7:0][15:0] cf_o;
  logic [7:0][23:0] fi_o, of_o, gn_o;
  int fails = 0;
  int n_compared = 0;
  int n_res = 0;
  int n_pop = 0;
  // id value is arbitrary
  acr_reg_bank #(.GAIN_FACTORY(24'h555555), .ID_VALUE(8'h5a)) DUT (
    .clk, .rst, .sclk, .cs_n, .mosi, .miso, .miso_oe, .rdy_in, .current_channel, .result_in,
    .mclk_tally_in, .q_stat_in, .q_data_in, .fault_set, .result_rd, .q_pop, .ctrl_o, .io_o,
    .vb_o, .fault_o, .fen_o, .misc_o, .qc_o, .qt_o, .ch_o, .cf_o, .fi_o, .of_o, .gn_o
  );
  acr_host_model host (.clk, .miso, .sclk, .cs_n, .mosi);
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (result_rd === 1'b1) n_res++;
    if (q_pop === 1'b1) n_pop++;
  end
  // ******************************
  // shared helpers
  // ******************************
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  function automatic int len_of(input logic [5:0] a);
    if (a inside {6'h00, 6'h05, 6'h08, 6'h3b} || a > 6'h3d) return 8;
    if (a inside {6'h01, 6'h03, 6'h04, 6'h06, 6'h07, 6'h39}) return 16;
    if (a >= 6'h19 && a <= 6'h20) return 16;
    return 24;
  endfunction : len_of
  function automatic logic [23:0] exp_rst(input logic [5:0] a);
    if (a == 6'h01) return 24'h004000;
    if (a == 6'h07) return 24'h000040;
    if (a == 6'h09) return 24'h800100;
    if (a >= 6'h0a && a <= 6'h18) return 24'h000100;
    if (a >= 6'h21 && a <= 6'h28) return 24'h002030;
    if (a >= 6'h29 && a <= 6'h30) return 24'h800000;
    if (a >= 6'h31 && a <= 6'h38) return 24'h555555;
    if (a == 6'h3a) return 24'h040200;
    if (a == 6'h3c) return 24'hfff000;
    return 24'h0;
  endfunction : exp_rst
  task automatic wr_reg(input logic [5:0] a, input logic [23:0] v);
    logic [23:0] d;
    host.xfer(1'b0, a, len_of(a), v, d);
  endtask : wr_reg
  task automatic rd_chk(input string what, input logic [5:0] a, input logic [23:0] exp);
    logic [23:0] v;
    host.xfer(1'b1, a, len_of(a), 24'h0, v);
    check(what, exp, v);
  endtask : rd_chk
  // ******************************
  // scenarios
  // ******************************
  task automatic t_por_status();
    rd_chk("status after reset", 6'h00, 24'h10);
    rd_chk("status second read", 6'h00, 24'h00);
  endtask : t_por_status
  task automatic t_reset_scan();
    check("ch0 port", 24'h800100, ch_o[0]);
    check("qc port", 24'h040200, qc_o);
    check("qt port", 24'hfff000, qt_o);
    for (int i = 1; i < 16; i++) check("chN port", 24'h000100, ch_o[i]);
    for (int i = 0; i < 8; i++)
    begin
      check("cf port", 24'h0, {8'h0, cf_o[i]});
      check("fi port", 24'h002030, fi_o[i]);
      check("of port", 24'h800000, of_o[i]);
      check("gn port", 24'h555555, gn_o[i]);
    end
    for (int a = 1; a <= 60; a++)
      if (!(a inside {2, 5, 8, 59}))
        rd_chk($sformatf("reset reg %h", a), 6'(a), exp_rst(6'(a)));
  endtask : t_reset_scan
  task automatic t_write_masks();
    logic [5:0] ad [7] = '{6'h01, 6'h03, 6'h04, 6'h07, 6'h21, 6'h30, 6'h38};
    logic [23:0] ex [7] = '{24'h7f7f, 24'h07ee, 24'hcc33, 24'h1fff, 24'hfff7ff,
                            24'hffffff, 24'hffffff};
    for (int i = 0; i < 7; i++)
    begin
      wr_reg(ad[i], 24'hffffff);
      rd_chk($sformatf("masked reg %h", ad[i]), ad[i], ex[i]);
    end
    check("ctrl port", 24'h7f7f, {8'h0, ctrl_o});
    check("io port", 24'h07ee, {8'h0, io_o});
    check("vb port", 24'hcc33, {8'h0, vb_o});
    check("fen port", 24'h1fff, {8'h0, fen_o});
    wr_reg(6'h02, 24'habcdef);
    check("write fault", 24'h8, {12'h0, fault_o});
    rd_chk("result kept", 6'h02, 24'h0);
    wr_reg(6'h06, 24'h0008);
    check("fault cleared", 24'h0, {12'h0, fault_o});
    wr_reg(6'h00, 24'hff);
    rd_chk("status kept", 6'h00, 24'h40);
    wr_reg(6'h06, 24'hffff);
  endtask : t_write_masks
  task automatic t_command();
    logic [23:0] v;
    host.open_frame();
    check("oe in frame", 24'h1, {23'h0, miso_oe});
    host.shift(24'hc1, 8, v);
    host.access(1'b0, 6'h39, 16, 24'ha5c3, v);
    host.access(1'b1, 6'h39, 16, 24'h0, v);
    host.close_frame();
    check("oe and data released", 24'h0, {22'h0, miso_oe, miso});
    check("misc back to back", 24'ha5c3, v);
    check("misc port", 24'ha5c3, {8'h0, misc_o});
    rd_chk("unmapped read", 6'h3e, 24'h0);
    check("read fault", 24'h10, {12'h0, fault_o});
    wr_reg(6'h06, 24'h0010);
  endtask : t_command
  task automatic t_live();
    int c0;
    @(negedge clk);
    rdy_in = 1'b1;
    current_channel = 4'h5;
    result_in = 24'h123456;
    mclk_tally_in = 8'h3c;
    q_stat_in = 8'h81;
    q_data_in = 24'hfedcba;
    fault_set = 12'h001;
    @(negedge clk);
    fault_set = 12'h000;
    rd_chk("core fault", 6'h06, 24'h0001);
    rd_chk("live status", 6'h00, 24'hc5);
    c0 = n_res;
    rd_chk("result", 6'h02, 24'h123456);
    check("result pulses", 24'(c0 + 1), 24'(n_res));
    c0 = n_pop;
    rd_chk("queue head", 6'h3d, 24'hfedcba);
    check("pop pulses", 24'(c0 + 1), 24'(n_pop));
    rd_chk("tally", 6'h08, 24'h3c);
    rd_chk("queue status", 6'h3b, 24'h81);
    rd_chk("ident", 6'h05, 24'h5a);
  endtask : t_live
  initial
  begin
    rst = 1'b1;
    rdy_in = 1'b0;
    current_channel = 4'h0;
    result_in = 24'h0;
    mclk_tally_in = 8'h0;
    q_stat_in = 8'h0;
    q_data_in = 24'h0;
    fault_set = 12'h0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_por_status();
    t_reset_scan();
    t_write_masks();
    t_command();
    t_live();
    give_verdict();
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    fails++;
    $display("[FAIL] run length expected end seen limit");
    give_verdict();
  end
endmodule : adc_user_config_register_map_test
`default_nettype wire
